// ### bench/tsbsc_hwy_model.sv
// highway source model: one frame of 24 slot bytes per go pulse
// assumes go_i is a one-cycle pulse from the bench
`timescale 1ns/100ps
module tsbsc_hwy_model (
   // clock, reset, command
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic go_i,
   input wire logic [7:0] base_i,
   // highway side
   output logic hw_frame_start_o = 1'b0,
   output logic hw_wr_o = 1'b0,
   output logic [4:0] hw_slot_o = 5'h00,
   output logic [7:0] hw_data_o = 8'h00
);
   logic [4:0] cnt_q;
   logic act_q;
   ////////////////////////////////////////////////////////////////////////////
   // byte is base plus slot; idle data toggles so a stale byte never looks live
   always @(posedge sys_clk_i) begin
      hw_frame_start_o <= 1'b0;
      hw_wr_o <= 1'b0;
      hw_data_o <= ~hw_data_o;
      if (sys_rst_i) begin
         act_q <= 1'b0;
      end else if (go_i) begin
         act_q <= 1'b1;
         cnt_q <= 5'h00;
      end else if (act_q) begin
         hw_wr_o <= 1'b1;
         hw_frame_start_o <= (cnt_q == 5'h00);
         hw_slot_o <= cnt_q;
         hw_data_o <= base_i + 8'(cnt_q);
         act_q <= (cnt_q != 5'h17);
         cnt_q <= cnt_q + 5'h01;
      end
   end
endmodule

// ### bench/tx_slip_buffer_slot_control_bench.sv
// self-checking bench for the transmit slip buffer and slot enables
// assumes one 20 MHz clock and the highway model beside the design
`timescale 1ns/100ps
module tx_slip_buffer_slot_control_bench import tsbsc_pkg::*;;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic go = 1'b0;
   logic line_frame_start_i = 1'b0;
   logic line_rd_i = 1'b0;
   logic [8:0] reg_addr_i = 9'h000;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [7:0] base = 8'h00;
   logic [4:0] line_slot_i = 5'h00;
   logic hw_frame_start_i, hw_wr_i, line_valid_o;
   logic [4:0] hw_slot_i;
   logic [7:0] hw_data_i, reg_rdata_o, line_data_o;
   logic [23:0] ena = 24'h80a501;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////////
   // clock, timeout and instances
   always #25 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         final_report();
      end
   end
   tsbsc_hwy_model u_hwy (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .go_i(go),
      .base_i(base), .hw_frame_start_o(hw_frame_start_i), .hw_wr_o(hw_wr_i),
      .hw_slot_o(hw_slot_i), .hw_data_o(hw_data_i));
   tsbsc_top u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .hw_frame_start_i(hw_frame_start_i), .hw_wr_i(hw_wr_i),
      .hw_slot_i(hw_slot_i), .hw_data_i(hw_data_i), .line_frame_start_i(line_frame_start_i),
      .line_rd_i(line_rd_i), .line_slot_i(line_slot_i), .line_data_o(line_data_o),
      .line_valid_o(line_valid_o));
   ////////////////////////////////////////////////////////////////////////////
   // shared compare, host bus and line tasks
   task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   // write then read back in the very next cycle, no gap between strobes
   task automatic wr_rd_chk(input logic [8:0] a, input logic [7:0] d, input logic [7:0] exp);
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 check_val(reg_rdata_o, exp);
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 check_val(reg_rdata_o, exp);
   endtask
   task automatic fetch(input logic [4:0] s, input logic st, input logic [7:0] exp);
      @(posedge sys_clk_i);
      line_rd_i <= 1'b1;
      line_slot_i <= s;
      line_frame_start_i <= st;
      @(posedge sys_clk_i);
      line_rd_i <= 1'b0;
      line_frame_start_i <= 1'b0;
      #1 check_val({7'h00, line_valid_o}, 8'h01);
      check_val(line_data_o, exp);
      @(posedge sys_clk_i);
      #1 check_val({7'h00, line_valid_o}, 8'h00);
   endtask
   // fixed wait covers the model's 24 slots plus its start cycle
   task automatic send_frame(input logic [7:0] b);
      @(posedge sys_clk_i);
      go <= 1'b1;
      base <= b;
      @(posedge sys_clk_i);
      go <= 1'b0;
      repeat (27) @(posedge sys_clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_regs();
      rd_chk(TSBSC_FRAME_ONE_OFS, TSBSC_BUF_RST);
      rd_chk(TSBSC_BUF_LAST_OFS, TSBSC_BUF_RST);
      rd_chk(9'h1c0, TSBSC_UNMAPPED_RD);
      reg_wr(TSBSC_ENA_LOW_OFS, ena[7:0]);
      wr_rd_chk(TSBSC_ENA_MID_OFS, ena[15:8], 8'ha5);
      reg_wr(TSBSC_ENA_HIGH_OFS, ena[23:16]);
      reg_wr(9'h1e7, 8'hff);
      rd_chk(TSBSC_ENA_LOW_OFS, 8'h01);
      rd_chk(TSBSC_ENA_MID_OFS, 8'ha5);
      rd_chk(TSBSC_ENA_HIGH_OFS, 8'h80);
      rd_chk(9'h1e7, TSBSC_UNMAPPED_RD);
   endtask
   // first frame lands in frame two; disabled slots stay at reset value
   task automatic t_highway();
      send_frame(8'h40);
      for (int i = 0; i < 24; i++) begin
         rd_chk(TSBSC_FRAME_TWO_OFS + 9'(i), ena[i] ? 8'h40 + 8'(i) : 8'h00);
      end
      rd_chk(TSBSC_FRAME_ONE_OFS, 8'h00);
   endtask
   task automatic t_force();
      reg_wr(9'h191, 8'h7e);
      reg_wr(9'h1a9, 8'h7e);
      send_frame(8'h80);
      rd_chk(TSBSC_FRAME_ONE_OFS, 8'h80);
      rd_chk(9'h191, 8'h7e);
      rd_chk(9'h1a9, 8'h7e);
   endtask
   task automatic t_line();
      fetch(5'h00, 1'b1, 8'h80);
      fetch(5'h01, 1'b0, 8'h7e);
      fetch(5'h17, 1'b0, 8'h97);
      fetch(5'h00, 1'b1, 8'h40);
      fetch(5'h01, 1'b0, 8'h7e);
      @(posedge sys_clk_i);
      line_rd_i <= 1'b1;
      line_slot_i <= 5'h18;
      @(posedge sys_clk_i);
      line_rd_i <= 1'b0;
      #1 check_val({7'h00, line_valid_o}, 8'h00);
      check_val(line_data_o, 8'h7e);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      t_regs();
      t_highway();
      t_force();
      t_line();
      final_report();
   end
endmodule

// ### core/tsbsc_pkg.sv
// constants for the transmit slip buffer and its per-slot enables
// assumes an 8-bit host port with 9-bit per-framer offsets
//
// Overview of operation
// - enabled slot: highway byte stored, then sent
// - disabled slot: host code stored and sent
// - enables in three bytes, bit 7 highest
// - frame one: 24 bytes from 0x190
// - frame two: 24 bytes from 0x1a8
// - channel n at frame base plus n-1
// - disabled slot keeps its stored bytes
package tsbsc_pkg;
   localparam int TSBSC_AW = 9;
   localparam int TSBSC_DW = 8;
   localparam int TSBSC_NCH = 24;
   localparam int TSBSC_NLOC = 48;
   // buffer window and enable offsets
   localparam logic [8:0] TSBSC_FRAME_ONE_OFS = 9'h190;
   localparam logic [8:0] TSBSC_FRAME_TWO_OFS = 9'h1a8;
   localparam logic [8:0] TSBSC_BUF_LAST_OFS = 9'h1bf;
   localparam logic [8:0] TSBSC_ENA_LOW_OFS = 9'h1e4;
   localparam logic [8:0] TSBSC_ENA_MID_OFS = 9'h1e5;
   localparam logic [8:0] TSBSC_ENA_HIGH_OFS = 9'h1e6;
   // reset values
   localparam logic [23:0] TSBSC_ENA_RST = 24'h000000;
   localparam logic [7:0] TSBSC_BUF_RST = 8'h00;
   localparam logic [7:0] TSBSC_UNMAPPED_RD = 8'h00;
   // second-frame base index and last frame slot
   localparam logic [5:0] TSBSC_FRAME_TWO_IDX = 6'h18;
   localparam logic [4:0] TSBSC_LAST_SLOT = 5'h17;
endpackage

// ### core/tsbsc_top.sv
// two-frame transmit slip buffer with per-slot highway enables
// assumes highway and line strobes are synchronous to sys_clk_i
`timescale 1ns/100ps
module tsbsc_top
   import tsbsc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // host register port
   input wire logic [8:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // transmit data highway
   input wire logic hw_frame_start_i,
   input wire logic hw_wr_i,
   input wire logic [4:0] hw_slot_i,
   input wire logic [7:0] hw_data_i,
   // transmit line framer
   input wire logic line_frame_start_i,
   input wire logic line_rd_i,
   input wire logic [4:0] line_slot_i,
   output logic [7:0] line_data_o,
   output logic line_valid_o
);

   ////////////////////////////////////////////////////////////////
   // storage

   logic [7:0] buf_q [0:TSBSC_NLOC-1];
   logic [23:0] ena_q;
   logic wfrm_q;
   logic rfrm_q;

   ////////////////////////////////////////////////////////////////
   // address decode

   logic host_buf_hit;
   logic [5:0] host_idx;
   logic host_buf_wr;
   logic ena_low_hit;
   logic ena_mid_hit;
   logic ena_high_hit;

   // one contiguous window covers both frames, ascending channel
   assign host_buf_hit = (reg_addr_i >= TSBSC_FRAME_ONE_OFS) &&
                         (reg_addr_i <= TSBSC_BUF_LAST_OFS);
   assign host_idx = 6'(reg_addr_i - TSBSC_FRAME_ONE_OFS);
   assign host_buf_wr = reg_wr_i && host_buf_hit;
   assign ena_low_hit = (reg_addr_i == TSBSC_ENA_LOW_OFS);
   assign ena_mid_hit = (reg_addr_i == TSBSC_ENA_MID_OFS);
   assign ena_high_hit = (reg_addr_i == TSBSC_ENA_HIGH_OFS);

   ////////////////////////////////////////////////////////////////
   // frame pointers

   logic wfrm_now;
   logic rfrm_now;

   // a frame start applies to the slot that arrives with it
   assign wfrm_now = wfrm_q ^ hw_frame_start_i;
   assign rfrm_now = rfrm_q ^ line_frame_start_i;

   // highway side picks the frame it fills
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         wfrm_q <= 1'b0;
      end else begin
         wfrm_q <= wfrm_now;
      end
   end

   // line side swaps frames once per frame period
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rfrm_q <= 1'b1;
      end else begin
         rfrm_q <= rfrm_now;
      end
   end

   ////////////////////////////////////////////////////////////////
   // highway write qualification

   logic hw_slot_ok;
   logic hw_slot_en;
   logic hw_buf_wr;
   logic [5:0] hw_idx;

   assign hw_slot_ok = hw_wr_i && (hw_slot_i <= TSBSC_LAST_SLOT);
   assign hw_slot_en = hw_slot_ok && ena_q[hw_slot_i];
   assign hw_buf_wr = hw_slot_en;
   assign hw_idx = wfrm_now ? (6'(hw_slot_i) + TSBSC_FRAME_TWO_IDX)
                            : 6'(hw_slot_i);

   ////////////////////////////////////////////////////////////////
   // enable registers

   // each byte maps channels upward from bit 0
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ena_q <= TSBSC_ENA_RST;
      end else if (reg_wr_i) begin
         if (ena_low_hit) begin
            ena_q[7:0] <= reg_wdata_i;
         end
         if (ena_mid_hit) begin
            ena_q[15:8] <= reg_wdata_i;
         end
         if (ena_high_hit) begin
            ena_q[23:16] <= reg_wdata_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // buffer array

   // host write is ordered last so it wins a same-location clash;
   // an enabled slot is then overwritten again two frames later anyway
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < TSBSC_NLOC; i++) begin
            buf_q[i] <= TSBSC_BUF_RST;
         end
      end else begin
         if (hw_buf_wr) begin
            buf_q[hw_idx] <= hw_data_i;
         end
         if (host_buf_wr) begin
            buf_q[host_idx] <= reg_wdata_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // host read data

   // read data stand for one cycle only, zero otherwise
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= TSBSC_UNMAPPED_RD;
      end else if (!reg_rd_i) begin
         reg_rdata_o <= TSBSC_UNMAPPED_RD;
      end else if (host_buf_hit) begin
         reg_rdata_o <= buf_q[host_idx];
      end else if (ena_low_hit) begin
         reg_rdata_o <= ena_q[7:0];
      end else if (ena_mid_hit) begin
         reg_rdata_o <= ena_q[15:8];
      end else if (ena_high_hit) begin
         reg_rdata_o <= ena_q[23:16];
      end else begin
         reg_rdata_o <= TSBSC_UNMAPPED_RD;
      end
   end

   ////////////////////////////////////////////////////////////////
   // line readout

   logic line_slot_ok;
   logic [5:0] line_idx;

   assign line_slot_ok = line_rd_i && (line_slot_i <= TSBSC_LAST_SLOT);
   assign line_idx = rfrm_now ? (6'(line_slot_i) + TSBSC_FRAME_TWO_IDX)
                              : 6'(line_slot_i);

   // the line reads the frame picked by its own start toggle, independent of the highway's
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         line_data_o <= TSBSC_BUF_RST;
         line_valid_o <= 1'b0;
      end else begin
         line_valid_o <= line_slot_ok;
         if (line_slot_ok) begin
            line_data_o <= buf_q[line_idx];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks

   property p_enabled_store;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (hw_slot_ok && ena_q[hw_slot_i] &&
       !(host_buf_wr && host_idx == hw_idx))
      |=> buf_q[$past(hw_idx)] == $past(hw_data_i);
   endproperty
   a_enabled_store: assert property (p_enabled_store)
      else $error("enabled slot byte not stored");

   property p_host_store;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      host_buf_wr |=> buf_q[$past(host_idx)] == $past(reg_wdata_i);
   endproperty
   a_host_store: assert property (p_host_store)
      else $error("host code not stored");

   property p_frozen;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (hw_slot_ok && !ena_q[hw_slot_i] && !host_buf_wr)
      |=> buf_q[$past(hw_idx)] == $past(buf_q[hw_idx]);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("disabled slot changed");

   property p_ena_mid_rd;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (reg_wr_i && ena_mid_hit) ##1 (reg_rd_i && ena_mid_hit)
      |=> reg_rdata_o == $past(reg_wdata_i, 2);
   endproperty
   a_ena_mid_rd: assert property (p_ena_mid_rd)
      else $error("enable byte readback wrong");

   property p_ena_high_bit;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (reg_wr_i && ena_high_hit && reg_wdata_i[7]) |=> ena_q[23];
   endproperty
   a_ena_high_bit: assert property (p_ena_high_bit)
      else $error("bit 7 not channel 24");

   property p_frame_one_rd;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (reg_rd_i && host_buf_hit && reg_addr_i < TSBSC_FRAME_TWO_OFS)
      |=> reg_rdata_o == $past(buf_q[host_idx]) && $past(host_idx) < TSBSC_FRAME_TWO_IDX;
   endproperty
   a_frame_one_rd: assert property (p_frame_one_rd)
      else $error("frame one read wrong");

   property p_frame_two_rd;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (reg_rd_i && reg_addr_i >= TSBSC_FRAME_TWO_OFS && host_buf_hit)
      |=> reg_rdata_o == $past(buf_q[host_idx]) && $past(host_idx) >= TSBSC_FRAME_TWO_IDX;
   endproperty
   a_frame_two_rd: assert property (p_frame_two_rd)
      else $error("frame two read wrong");

   property p_line_slot;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      line_slot_ok |=> line_valid_o &&
         line_data_o == $past(buf_q[6'(line_slot_i) +
                                    (rfrm_now ? TSBSC_FRAME_TWO_IDX : 6'h00)]);
   endproperty
   a_line_slot: assert property (p_line_slot)
      else $error("line byte from wrong location");

   property p_alternate;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      line_frame_start_i |=> rfrm_q != $past(rfrm_q);
   endproperty
   a_alternate: assert property (p_alternate)
      else $error("readout frame did not swap");

   property p_hold_frame;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !line_frame_start_i [*2] |-> $stable(rfrm_q);
   endproperty
   a_hold_frame: assert property (p_hold_frame)
      else $error("readout frame swapped early");

   // register side: enables written only where addressed, read data one cycle wide
   property p_ena_low_wr;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (reg_wr_i && ena_low_hit) |=> ena_q[7:0] == $past(reg_wdata_i);
   endproperty
   a_ena_low_wr: assert property (p_ena_low_wr)
      else $error("low enable byte not written");

   // enables move only on a host write to one of their three bytes
   property p_ena_hold;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !(reg_wr_i && (ena_low_hit || ena_mid_hit || ena_high_hit)) |=> $stable(ena_q);
   endproperty
   a_ena_hold: assert property (p_ena_hold)
      else $error("enable bits changed without a write");

   property p_rdata_idle;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !reg_rd_i |=> reg_rdata_o == TSBSC_UNMAPPED_RD;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data stood past its cycle");

   // stream side: fill frame swaps, refused slots and holding line byte
   property p_wr_alternate;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      hw_frame_start_i |=> wfrm_q != $past(wfrm_q);
   endproperty
   a_wr_alternate: assert property (p_wr_alternate)
      else $error("fill frame did not swap");

   property p_line_refused;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (line_rd_i && line_slot_i > TSBSC_LAST_SLOT) |=> !line_valid_o;
   endproperty
   a_line_refused: assert property (p_line_refused)
      else $error("out of range slot fetched");

   // a slot the line did not fetch leaves the line byte alone
   property p_line_hold;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !line_slot_ok |=> $stable(line_data_o);
   endproperty
   a_line_hold: assert property (p_line_hold)
      else $error("line byte changed without a fetch");

endmodule
